// *** verilog/loop_cal_pkg.sv ***
// constants and types shared by the calibration and enable control block
`default_nettype none
package loop_cal_pkg;
	// ****************************************
	// register layout
	// ****************************************
	localparam logic [15:0] CAL_MODE_RESET   = 16'h024b;
	localparam logic [15:0] CAL_MODE_ONCE    = 16'h024b;
	localparam logic [15:0] CAL_MODE_FIRST   = 16'h124b;
	localparam logic [15:0] CAL_MODE_REPEAT  = 16'h034b;
	localparam logic [15:0] CAL_MODE_OFF     = 16'h004b;
	localparam int          CAL_ENABLE_BIT   = 9;
	localparam int          CAL_STORE_BIT    = 2;
	localparam int          CAL_CONT_BIT     = 8;
	localparam int          CAL_FIRST_BIT    = 12;
	localparam int          RES_FREQ_WIDTH   = 16;
	// ****************************************
	// loop settings, fixed point: gain Q8, damping Q8
	// ****************************************
	localparam logic [15:0] GAIN_RESET       = 16'h0080;
	localparam logic [15:0] DAMPING_RESET    = 16'h0180;
	localparam int          BANDWIDTH_PCT    = 10;
	// ****************************************
	// on/off configuration bits
	// ****************************************
	localparam int          ONOFF_PIN_BIT    = 0;
	localparam int          ONOFF_BUS_BIT    = 1;
	localparam int          ONOFF_ALWAYS_BIT = 2;
	localparam int          ONOFF_INVERT_BIT = 3;
	localparam logic [3:0]  ONOFF_RESET      = 4'h1;
	// ****************************************
	// timing
	// ****************************************
	localparam int          CLOCK_MHZ        = 100;
	localparam int          REPEAT_MS        = 800;
	localparam int          REPEAT_CYCLES    = REPEAT_MS * 1000 * CLOCK_MHZ;
	typedef enum logic [2:0] {
		IDLE    = 3'b000,
		RAMP    = 3'b001,
		MEASURE = 3'b010,
		STORE   = 3'b011,
		WAIT    = 3'b100,
		RUN     = 3'b101
	} cal_state_t;
endpackage : loop_cal_pkg
`default_nettype wire

// *** verilog/measure_if.sv ***
// handshake between the sequencer and the measurement engine
`timescale 1ns/1ps
`default_nettype none
interface measure_if;
	logic        start;
	logic        done;
	logic [15:0] result;
	modport seq (output start, input done, input result);
	modport eng (input start, output done, output result);
endinterface : measure_if
`default_nettype wire

// *** verilog/measure_engine.sv ***
// drives the probe signal and captures the measured resonance frequency
`timescale 1ns/1ps
`default_nettype none
module measure_engine
	import loop_cal_pkg::*;
(
	// clock and reset
	input  wire logic clock,
	input  wire logic reset,
	// handshake to sequencer
	measure_if.eng    meas,
	// analog front end
	output logic      probeOn,
	input  wire logic resultValid,
	input  wire logic [15:0] resultValue
);
	logic        busy;
	logic        next_busy;
	logic        done;
	logic        next_done;
	logic [15:0] result;
	logic [15:0] next_result;

	always_comb begin
		next_busy   = busy;
		next_done   = 1'b0;
		next_result = result;
		if (busy && resultValid) begin
			next_busy   = 1'b0;
			next_done   = 1'b1;
			next_result = resultValue;
		end else if (meas.start) begin
			next_busy = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			busy   <= 1'b0;
			done   <= 1'b0;
			result <= 16'h0000;
		end else begin
			busy   <= next_busy;
			done   <= next_done;
			result <= next_result;
		end
	end

	assign probeOn     = busy;
	assign meas.done   = done;
	assign meas.result = result;
endmodule : measure_engine
`default_nettype wire

// *** verilog/loop_cal_ctrl.sv ***
// calibration scheduling, resonance value selection and output enable
// ****************************************
// Contract
// - ramp-up uses stored resonance frequency
// - calibration off keeps ramp value afterwards
// - calibration enabled measures right after ramp
// - measured value written into model register
// - disable restores value from user store
// - bit 2 stores to user memory after calibration
// - 0x024B calibrates once per ramp-up
// - 0x124B calibrates after first power-up ramp
// - 0x034B repeats calibration every 800 ms
// - 0x004B no calibration, stored value applied
// - bit 8 runs continuous calibration
// - defaults gain 0.5, damping 1.5
// - negative duty option settable
// - enable by pin, bus or always
// - pin polarity positive, invertible
// - power good needs calibration done
// ****************************************
`timescale 1ns/1ps
`default_nettype none
module loop_cal_ctrl
	import loop_cal_pkg::*;
#(
	parameter int REPEAT_COUNT = REPEAT_CYCLES
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// register writes from the serial bus decoder
	input  wire logic        calModeWrite,
	input  wire logic [15:0] calModeData,
	input  wire logic        modelWrite,
	input  wire logic [15:0] modelData,
	input  wire logic        gainWrite,
	input  wire logic [15:0] gainData,
	input  wire logic        dampingWrite,
	input  wire logic [15:0] dampingData,
	input  wire logic        loopCfgWrite,
	input  wire logic        loopCfgNegDuty,
	input  wire logic        onOffWrite,
	input  wire logic [3:0]  onOffData,
	input  wire logic        busOn,
	input  wire logic [15:0] userStoreFreq,
	// remote control pin
	input  wire logic        remotePin,
	// regulator core
	input  wire logic        rampDone,
	input  wire logic        aboveGoodLevel,
	input  wire logic        resultValid,
	input  wire logic [15:0] resultValue,
	// register read back
	output logic [15:0]      calMode,
	output logic [15:0]      compModel,
	output logic [15:0]      gain,
	output logic [15:0]      dampingRatio,
	output logic             negDutyEnable,
	output logic [3:0]       onOffConfig,
	// to regulator core
	output logic             outputEnable,
	output logic [15:0]      resonanceFrequency,
	output logic             probeActive,
	output logic             storeUserAll,
	output logic             calDone,
	output logic             powerGoodOut
);
	// ****************************************
	// pin synchroniser
	// ****************************************
	logic pinMeta;
	logic pinSync;
	always_ff @(posedge clock) begin
		if (reset) begin
			pinMeta <= 1'b1;
			pinSync <= 1'b1;
		end else begin
			pinMeta <= remotePin;
			pinSync <= pinMeta;
		end
	end

	// ****************************************
	// measurement engine
	// ****************************************
	measure_if meas ();
	logic probeOn;
	measure_engine engine (
		.clock       (clock),
		.reset       (reset),
		.meas        (meas.eng),
		.probeOn     (probeOn),
		.resultValid (resultValid),
		.resultValue (resultValue)
	);

	// ****************************************
	// state
	// ****************************************
	cal_state_t  state;
	cal_state_t  next_state;
	logic [15:0] next_calMode;
	logic [15:0] next_compModel;
	logic [15:0] next_gain;
	logic [15:0] next_dampingRatio;
	logic        next_negDutyEnable;
	logic [3:0]  next_onOffConfig;
	logic        next_outputEnable;
	logic        next_probeActive;
	logic        next_storeUserAll;
	logic        next_calDone;
	logic        next_powerGoodOut;
	logic        firstDone;
	logic        next_firstDone;
	logic [31:0] waitCount;
	logic [31:0] next_waitCount;
	logic        start;
	logic        pinOn;
	logic        enableReq;
	logic        calEnabled;
	logic        repeatMode;

	assign meas.start = start;

	always_comb begin
		// polarity select, default high means on
		pinOn = pinSync ^ onOffConfig[ONOFF_INVERT_BIT];
		enableReq = onOffConfig[ONOFF_ALWAYS_BIT]
			| ((~onOffConfig[ONOFF_PIN_BIT] | pinOn)
			& (~onOffConfig[ONOFF_BUS_BIT] | busOn)
			& (onOffConfig[ONOFF_PIN_BIT]
			| onOffConfig[ONOFF_BUS_BIT]));
		calEnabled = calMode[CAL_ENABLE_BIT]
			& ~(calMode[CAL_FIRST_BIT] & firstDone);
		repeatMode = calMode[CAL_CONT_BIT];
	end

	always_comb begin
		next_state         = state;
		next_calMode       = calMode;
		next_compModel     = compModel;
		next_gain          = gain;
		next_dampingRatio  = dampingRatio;
		next_negDutyEnable = negDutyEnable;
		next_onOffConfig   = onOffConfig;
		next_outputEnable  = enableReq;
		next_probeActive   = probeOn;
		next_storeUserAll  = 1'b0;
		next_calDone       = calDone;
		next_firstDone     = firstDone;
		next_waitCount     = waitCount;
		start              = 1'b0;
		// mode is only read at scheduling points below
		if (calModeWrite) begin
			next_calMode = calModeData;
		end
		if (modelWrite) begin
			next_compModel = modelData;
		end
		if (gainWrite) begin
			next_gain = gainData;
		end
		if (dampingWrite) begin
			next_dampingRatio = dampingData;
		end
		if (loopCfgWrite) begin
			next_negDutyEnable = loopCfgNegDuty;
		end
		if (onOffWrite) begin
			next_onOffConfig = onOffData;
		end
		unique case (state)
			IDLE: begin
				if (enableReq) begin
					next_state = RAMP;
				end
			end
			RAMP: begin
				if (rampDone) begin
					if (calEnabled) begin
						start      = 1'b1;
						next_state = MEASURE;
					end else begin
						next_calDone = 1'b1;
						next_state   = RUN;
					end
				end
			end
			MEASURE: begin
				if (meas.done) begin
					next_compModel = meas.result;
					next_calDone   = 1'b1;
					next_firstDone = 1'b1;
					next_state     = calMode[CAL_STORE_BIT] ? STORE : WAIT;
				end
			end
			STORE: begin
				next_storeUserAll = 1'b1;
				// a host write in this cycle wins over the self-clear
				if (!calModeWrite) begin
					next_calMode = calMode
						& ~(16'h0001 << CAL_STORE_BIT);
				end
				next_state = WAIT;
			end
			WAIT: begin
				next_waitCount = 32'h0000_0000;
				next_state     = RUN;
			end
			RUN: begin
				if (repeatMode) begin
					next_waitCount = waitCount + 32'h0000_0001;
					if (waitCount >= 32'(REPEAT_COUNT - 1)) begin
						next_waitCount = 32'h0000_0000;
						start          = 1'b1;
						next_state     = MEASURE;
					end
				end else begin
					next_waitCount = 32'h0000_0000;
				end
			end
			default: next_state = IDLE;
		endcase
		if (!enableReq) begin
			next_state     = IDLE;
			next_calDone   = 1'b0;
			// restore on the falling enable only, so host edits
			// made while disabled survive until the next ramp
			if (outputEnable) begin
				next_compModel = userStoreFreq;
			end
		end
		next_powerGoodOut = next_calDone & aboveGoodLevel
			& enableReq;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state         <= IDLE;
			calMode       <= CAL_MODE_RESET;
			compModel     <= 16'h0000;
			gain          <= GAIN_RESET;
			dampingRatio  <= DAMPING_RESET;
			negDutyEnable <= 1'b0;
			onOffConfig   <= ONOFF_RESET;
			outputEnable  <= 1'b0;
			probeActive   <= 1'b0;
			storeUserAll  <= 1'b0;
			calDone       <= 1'b0;
			powerGoodOut  <= 1'b0;
			firstDone     <= 1'b0;
			waitCount     <= 32'h0000_0000;
		end else begin
			state         <= next_state;
			calMode       <= next_calMode;
			compModel     <= next_compModel;
			gain          <= next_gain;
			dampingRatio  <= next_dampingRatio;
			negDutyEnable <= next_negDutyEnable;
			onOffConfig   <= next_onOffConfig;
			outputEnable  <= next_outputEnable;
			probeActive   <= next_probeActive;
			storeUserAll  <= next_storeUserAll;
			calDone       <= next_calDone;
			powerGoodOut  <= next_powerGoodOut;
			firstDone     <= next_firstDone;
			waitCount     <= next_waitCount;
		end
	end

	// ramp and post-ramp both use the model field
	always_ff @(posedge clock) begin
		if (reset) begin
			resonanceFrequency <= 16'h0000;
		end else begin
			resonanceFrequency <= next_compModel;
		end
	end
endmodule : loop_cal_ctrl
`default_nettype wire

// *** tb/core_model.sv ***
// regulator core and measurement front end as seen by the block
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// from the block
	input  wire logic        outputEnable,
	input  wire logic        probeActive,
	// answer timing and value
	input  wire logic [7:0]  measDelay,
	input  wire logic [15:0] measValue,
	// back to the block
	output logic             rampDone,
	output logic             aboveGoodLevel,
	output logic             resultValid,
	output logic [15:0]      resultValue
);
	int   rampCount;
	int   measCount;
	logic sent;
	// ****************************************
	// ramp and one result per probe
	// ****************************************
	always_ff @(posedge clock) begin
		rampDone       <= (rampCount >= 6);
		aboveGoodLevel <= (rampCount >= 6);
		rampCount      <= (reset || !outputEnable) ? 0 : rampCount + 1;
		resultValid    <= 1'b0;
		// no valid data outside the strobe
		resultValue    <= ~resultValue;
		if (reset || !probeActive) begin
			measCount   <= 0;
			sent        <= 1'b0;
			resultValue <= 16'h0000;
		end else if (!sent && measCount == int'(measDelay)) begin
			resultValid <= 1'b1;
			resultValue <= measValue;
			sent        <= 1'b1;
		end else begin
			measCount <= measCount + 1;
		end
	end
endmodule : core_model
`default_nettype wire

// *** tb/loop_cal_ctrl_properties.sv ***
// port assertions for the calibration and enable control block
`timescale 1ns/1ps
`default_nettype none
module loop_cal_ctrl_properties
	import loop_cal_pkg::*;
#(
	parameter int REPEAT_COUNT = 20
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        reset,
	// inputs
	input wire logic        calModeWrite,
	input wire logic [15:0] calModeData,
	input wire logic [15:0] userStoreFreq,
	input wire logic        remotePin,
	input wire logic        rampDone,
	input wire logic        resultValid,
	input wire logic [15:0] resultValue,
	// outputs
	input wire logic [15:0] calMode,
	input wire logic [15:0] compModel,
	input wire logic [3:0]  onOffConfig,
	input wire logic        outputEnable,
	input wire logic        probeActive,
	input wire logic        storeUserAll,
	input wire logic        calDone,
	input wire logic        powerGoodOut
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	property p_modeRead;
		calModeWrite |=> calMode == $past(calModeData); endproperty
	a_modeRead: assert property (p_modeRead) else $error("mode");
	property p_result;
		resultValid && outputEnable |-> ##2
			compModel == $past(resultValue, 2) && calDone; endproperty
	a_result: assert property (p_result) else $error("result");
	property p_restore;
		$fell(outputEnable) |-> ##[1:2] compModel == userStoreFreq; endproperty
	a_restore: assert property (p_restore) else $error("restore");
	property p_store;
		storeUserAll |=> !storeUserAll && !calMode[CAL_STORE_BIT]; endproperty
	a_store: assert property (p_store) else $error("store");
	property p_pin;
		onOffConfig == ONOFF_RESET && $rose(remotePin) |-> ##[2:4] outputEnable;
	endproperty
	a_pin: assert property (p_pin) else $error("pin");
	property p_always;
		onOffConfig[ONOFF_ALWAYS_BIT] |-> ##[0:3] outputEnable; endproperty
	a_always: assert property (p_always) else $error("always");
	property p_good;
		powerGoodOut |-> calDone; endproperty
	a_good: assert property (p_good) else $error("good");
	property p_probe;
		$rose(rampDone) && outputEnable && calMode == CAL_MODE_ONCE
			|-> ##[1:3] probeActive; endproperty
	a_probe: assert property (p_probe) else $error("probe");
	property p_off;
		calMode == CAL_MODE_OFF && !probeActive |=> !probeActive; endproperty
	a_off: assert property (p_off) else $error("off");
	c_store: cover property (storeUserAll);
	c_probe: cover property ($rose(probeActive));
	c_good: cover property ($rose(powerGoodOut));
endmodule : loop_cal_ctrl_properties
bind loop_cal_ctrl loop_cal_ctrl_properties #(.REPEAT_COUNT(REPEAT_COUNT))
	loop_cal_ctrl_properties_inst (.clock, .reset, .calModeWrite,
	.calModeData, .userStoreFreq, .remotePin, .rampDone, .resultValid,
	.resultValue, .calMode, .compModel, .onOffConfig, .outputEnable,
	.probeActive, .storeUserAll, .calDone, .powerGoodOut);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the calibration and enable control block
`timescale 1ns/1ps
`default_nettype none
module tb
	import loop_cal_pkg::*;
;
	localparam int MODE = 0, MODEL = 1, GAIN = 2, DAMP = 3, LOOP = 4, ONOFF = 5;
	localparam int DONE = 0, ON = 1, PROBE = 2, IDLE = 3;
	logic        clock, reset, calModeWrite, modelWrite, gainWrite;
	logic        dampingWrite, loopCfgWrite, loopCfgNegDuty, onOffWrite;
	logic        busOn, remotePin, negDutyEnable, outputEnable, probeActive;
	logic        storeUserAll, calDone, powerGoodOut, rampDone;
	logic        aboveGoodLevel, resultValid, probeLast = 1'b0;
	logic [15:0] calModeData, modelData, gainData, dampingData, userStoreFreq;
	logic [15:0] calMode, compModel, gain, dampingRatio, resonanceFrequency;
	logic [15:0] resultValue, measValue;
	logic [3:0]  onOffData, onOffConfig;
	logic [7:0]  measDelay;
	int          bad_count = 0, checks = 0, probeStarts = 0, stores = 0, base;
	loop_cal_ctrl #(.REPEAT_COUNT(20)) loop_cal_ctrl_inst (.clock, .reset,
		.calModeWrite, .calModeData, .modelWrite, .modelData, .gainWrite,
		.gainData, .dampingWrite, .dampingData, .loopCfgWrite,
		.loopCfgNegDuty, .onOffWrite, .onOffData, .busOn, .userStoreFreq,
		.remotePin, .rampDone, .aboveGoodLevel, .resultValid, .resultValue,
		.calMode, .compModel, .gain, .dampingRatio, .negDutyEnable,
		.onOffConfig, .outputEnable, .resonanceFrequency, .probeActive,
		.storeUserAll, .calDone, .powerGoodOut);
	core_model core_model_inst (.clock, .reset, .outputEnable, .probeActive,
		.measDelay, .measValue, .rampDone, .aboveGoodLevel, .resultValid,
		.resultValue);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		probeLast <= probeActive;
		if (probeActive === 1'b1 && probeLast !== 1'b1) probeStarts++;
		if (storeUserAll === 1'b1) stores++;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic wr(input int k, input logic [15:0] d);
		@(posedge clock);
		{calModeData, modelData, gainData, dampingData} <= {4{d}};
		loopCfgNegDuty <= d[0];
		onOffData      <= d[3:0];
		calModeWrite   <= (k == MODE);
		modelWrite     <= (k == MODEL);
		gainWrite      <= (k == GAIN);
		dampingWrite   <= (k == DAMP);
		loopCfgWrite   <= (k == LOOP);
		onOffWrite     <= (k == ONOFF);
		@(posedge clock);
		{calModeWrite, modelWrite, gainWrite, dampingWrite} <= 4'h0;
		{loopCfgWrite, onOffWrite} <= 2'h0;
	endtask : wr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic waitFor(input int s);
		logic [3:0] v;
		for (int i = 0; i < 500; i++) begin
			@(posedge clock);
			v = {!probeActive, probeActive, outputEnable, calDone};
			if (v[s] === 1'b1) return;
		end
		bad_count++;
		report_and_stop();
	endtask : waitFor
	task automatic pinOff();
		remotePin <= 1'b0;
		repeat (6) @(posedge clock);
	endtask : pinOff
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		reset = 1'b1;
		{calModeWrite, modelWrite, gainWrite, dampingWrite} = 4'h0;
		{loopCfgWrite, loopCfgNegDuty, onOffWrite, busOn, remotePin} = 5'h0;
		{calModeData, modelData, gainData, dampingData} = 64'h0;
		onOffData = 4'h0;
		userStoreFreq = 16'h0c35;
		measValue = 16'h1234;
		measDelay = 8'h05;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		chk(calMode, CAL_MODE_RESET);
		chk(gain, GAIN_RESET);
		chk(dampingRatio, DAMPING_RESET);
		chk(onOffConfig, ONOFF_RESET);
		wr(GAIN, 16'h00c0);
		wr(DAMP, 16'h0100);
		wr(LOOP, 16'h0001);
		@(posedge clock);
		chk(gain, 16'h00c0);
		chk(dampingRatio, 16'h0100);
		chk(negDutyEnable, 16'h0001);
		wr(MODEL, 16'h0400);
		repeat (2) @(posedge clock);
		chk(compModel, 16'h0400);
		remotePin <= 1'b1;
		waitFor(ON);
		repeat (2) @(posedge clock);
		chk(resonanceFrequency, 16'h0400);
		waitFor(DONE);
		repeat (2) @(posedge clock);
		chk(compModel, 16'h1234);
		chk(resonanceFrequency, 16'h1234);
		chk(powerGoodOut, 16'h0001);
		chk(probeStarts, 1);
		pinOff();
		chk(outputEnable, 16'h0000);
		chk(compModel, 16'h0c35);
		// slow answer with the store request armed
		measDelay <= 8'd40;
		wr(MODE, CAL_MODE_ONCE | 16'h0004);
		remotePin <= 1'b1;
		waitFor(PROBE);
		waitFor(IDLE);
		repeat (3) @(posedge clock);
		chk(stores, 1);
		chk(calMode, CAL_MODE_ONCE);
		chk(probeStarts, 2);
		pinOff();
		measValue <= 16'h0abc;
		remotePin <= 1'b1;
		waitFor(PROBE);
		wr(MODE, CAL_MODE_OFF);
		waitFor(IDLE);
		repeat (3) @(posedge clock);
		chk(compModel, 16'h0abc);
		pinOff();
		base = probeStarts;
		remotePin <= 1'b1;
		repeat (60) @(posedge clock);
		chk(probeStarts, base);
		chk(calDone, 16'h0001);
		chk(resonanceFrequency, 16'h0c35);
		pinOff();
		// first calibration since reset already ran, so none now
		wr(MODE, CAL_MODE_FIRST);
		remotePin <= 1'b1;
		repeat (60) @(posedge clock);
		chk(probeStarts, base);
		chk(calDone, 16'h0001);
		pinOff();
		measDelay <= 8'd2;
		wr(MODE, CAL_MODE_REPEAT);
		remotePin <= 1'b1;
		base = probeStarts;
		repeat (150) @(posedge clock);
		chk(probeStarts - base > 3, 16'h0001);
		wr(MODE, CAL_MODE_ONCE);
		repeat (20) @(posedge clock);
		base = probeStarts;
		repeat (100) @(posedge clock);
		chk(probeStarts, base);
		pinOff();
		wr(ONOFF, 16'h0002);
		busOn <= 1'b1;
		waitFor(ON);
		busOn <= 1'b0;
		repeat (6) @(posedge clock);
		chk(outputEnable, 16'h0000);
		wr(ONOFF, 16'h0009);
		waitFor(ON);
		remotePin <= 1'b1;
		repeat (6) @(posedge clock);
		chk(outputEnable, 16'h0000);
		wr(ONOFF, 16'h0004);
		repeat (6) @(posedge clock);
		chk(outputEnable, 16'h0001);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
